// file: rtl/arsc_pkg.sv
`default_nettype none
package arsc_pkg;
    // ------------------------------------------------------------
    // Select field layout
    // ------------------------------------------------------------
    localparam int SEL_W = 3;
    localparam int SEL_INT_BIT = 2;
    localparam int SEL_PIN_BIT = 1;
    localparam int SEL_KEEP_BIT = 0;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] SEL_AUTO_OFF = 3'h4;
    localparam int RES_W = 10;
    localparam int CH_W = 4;
    localparam logic [3:0] CH_LAST_SMALL = 4'h3;
    localparam logic [3:0] CH_LAST_LARGE = 4'hb;
    localparam logic [3:0] CH_LIMIT_SMALL = 4'h2;
    localparam logic [3:0] CH_LIMIT_LARGE = 4'ha;
    localparam logic [3:0] CH_RESET = 4'h0;
    // ------------------------------------------------------------
    // Reference wake-up timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 50000000;
    localparam longint WAKE_MS = 10;
    localparam longint WAKE_CYCLES = (CLK_HZ * WAKE_MS) / 1000;
    typedef enum logic [1:0] {ARSC_REF_SUPPLY, ARSC_REF_EXTERNAL, ARSC_REF_INTERNAL} arsc_ref_t;
    typedef enum logic [1:0] {ARSC_PIN_ANALOG, ARSC_PIN_REF_IN, ARSC_PIN_REF_OUT} arsc_pin_t;
endpackage : arsc_pkg
`default_nettype wire

// file: rtl/arsc_coder.sv
`timescale 1ns/1ps
`default_nettype none
module arsc_coder #(
    parameter int RES_W = 10
) (
    input wire logic [RES_W-1:0] raw,
    input wire logic bipolar,
    output logic [RES_W-1:0] coded
);
    // Raw is offset binary; bipolar flips the sign bit to give two's complement
    always_comb begin
        coded = raw;
        if (bipolar) begin
            coded[RES_W-1] = ~raw[RES_W-1];
        end
    end
endmodule : arsc_coder
`default_nettype wire

// file: rtl/arsc_ctrl.sv
// Contract
// - Top bit internal; else middle selects external
// - Keep-on bit matters only with internal
// - Reference pin reads as ground differentially
// - Scan limit channel 2 or 10
// - Both upper bits drive reference out
// - Powered reference stays on until reconfigured
// - No wake delay for supply/external reference
// - Unipolar straight binary, bipolar two's complement
// - Select 100 powers analog down when idle
// - Reset: channel 0, supply, analog pin
`timescale 1ns/1ps
`default_nettype none
module arsc_ctrl #(
    parameter longint WAKE_CYCLES = arsc_pkg::WAKE_CYCLES,
    parameter bit LARGE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic setup_wr,
    input wire logic [2:0] setup_sel,
    input wire logic setup_bipolar,
    input wire logic setup_diff,
    input wire logic conv_active,
    input wire logic conv_req,
    input wire logic [3:0] scan_ch,
    input wire logic diff_uses_pin,
    input wire logic [9:0] raw_result,
    output logic ref_internal,
    output logic ref_external,
    output logic ref_on,
    output logic ref_ready,
    output logic pin_ref_out_en,
    output logic pin_ref_in,
    output logic pin_force_gnd,
    output logic [3:0] scan_limit,
    output logic analog_on,
    output logic bipolar,
    output logic diff,
    output logic [9:0] result
);
    // ------------------------------------------------------------
    // Setup state
    // ------------------------------------------------------------
    logic [2:0] sel;
    logic [31:0] wake_cnt;
    logic [9:0] coded;
    logic int_sel;
    logic pin_sel;
    logic keep_sel;
    logic [3:0] limit;

    assign int_sel = sel[arsc_pkg::SEL_INT_BIT];
    assign pin_sel = sel[arsc_pkg::SEL_PIN_BIT];
    assign keep_sel = sel[arsc_pkg::SEL_KEEP_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= arsc_pkg::SEL_RESET;
            bipolar <= 1'b0;
            diff <= 1'b0;
        end else if (setup_wr) begin
            sel <= setup_sel;
            bipolar <= setup_bipolar;
            diff <= setup_diff;
        end
    end

    // ------------------------------------------------------------
    // Reference routing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_internal <= 1'b0;
            ref_external <= 1'b0;
            pin_ref_out_en <= 1'b0;
            pin_ref_in <= 1'b0;
        end else begin
            ref_internal <= int_sel;
            ref_external <= !int_sel && pin_sel;
            pin_ref_out_en <= int_sel && pin_sel;
            pin_ref_in <= !int_sel && pin_sel;
        end
    end

    // ------------------------------------------------------------
    // Internal reference power and wake-up
    // ------------------------------------------------------------
    // Once woken it stays on until the field changes; a rewrite with the
    // same value does not drop it.
    logic powered;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powered <= 1'b0;
        end else if (!int_sel) begin
            powered <= 1'b0;
        end else if (setup_wr && setup_sel != sel) begin
            powered <= 1'b0;
        end else if (keep_sel || conv_req || conv_active) begin
            powered <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_on <= 1'b0;
        end else begin
            ref_on <= powered;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= '0;
            ref_ready <= 1'b1;
        end else if (!int_sel) begin
            wake_cnt <= '0;
            ref_ready <= 1'b1;
        end else if (!powered) begin
            wake_cnt <= '0;
            ref_ready <= 1'b0;
        end else if (wake_cnt < 32'(WAKE_CYCLES)) begin
            wake_cnt <= wake_cnt + 32'h1;
            ref_ready <= 1'b0;
        end else begin
            ref_ready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Channel limiter and ground forcing
    // ------------------------------------------------------------
    always_comb begin
        limit = LARGE ? arsc_pkg::CH_LAST_LARGE : arsc_pkg::CH_LAST_SMALL;
        if (pin_sel) begin
            limit = LARGE ? arsc_pkg::CH_LIMIT_LARGE : arsc_pkg::CH_LIMIT_SMALL;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_limit <= arsc_pkg::CH_RESET;
            pin_force_gnd <= 1'b0;
        end else begin
            scan_limit <= (scan_ch > limit) ? limit : scan_ch;
            pin_force_gnd <= pin_sel && diff && diff_uses_pin;
        end
    end

    // ------------------------------------------------------------
    // Analog power and result coding
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_on <= 1'b1;
        end else begin
            analog_on <= (sel != arsc_pkg::SEL_AUTO_OFF) || conv_active || conv_req;
        end
    end

    arsc_coder #(.RES_W(arsc_pkg::RES_W)) arsc_coder_i (
        .raw(raw_result),
        .bipolar(bipolar),
        .coded(coded)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (conv_active) begin
            result <= coded;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ref_route;
        @(posedge clk) disable iff (!rst_n) 1'b1 |=> (ref_internal == $past(int_sel));
    endproperty
    a_ref_route: assert property (p_ref_route) else $error("reference routing wrong");
    property p_off_when_ext;
        @(posedge clk) disable iff (!rst_n) !int_sel |=> !powered;
    endproperty
    a_off_when_ext: assert property (p_off_when_ext) else $error("internal reference on");
    property p_gnd;
        @(posedge clk) disable iff (!rst_n) (pin_sel && diff && diff_uses_pin) |=> pin_force_gnd;
    endproperty
    a_gnd: assert property (p_gnd) else $error("pin not forced to ground");
    property p_limit;
        @(posedge clk) disable iff (!rst_n)
            pin_sel |=> scan_limit <= (LARGE ? arsc_pkg::CH_LIMIT_LARGE : arsc_pkg::CH_LIMIT_SMALL);
    endproperty
    a_limit: assert property (p_limit) else $error("scan limit exceeded");
    property p_out;
        @(posedge clk) disable iff (!rst_n) (int_sel && pin_sel) |=> pin_ref_out_en;
    endproperty
    a_out: assert property (p_out) else $error("reference out not driven");
    property p_hold;
        @(posedge clk) disable iff (!rst_n) (powered && int_sel && !setup_wr) |=> powered;
    endproperty
    a_hold: assert property (p_hold) else $error("reference dropped");
    // A rewrite with an unchanged field must not restart the wake-up
    sequence s_same_rewrite;
        powered && int_sel && setup_wr && (setup_sel == sel);
    endsequence
    property p_same_keep;
        @(posedge clk) disable iff (!rst_n) s_same_rewrite |=> powered;
    endproperty
    a_same_keep: assert property (p_same_keep) else $error("reference dropped on same rewrite");
    property p_nowake;
        @(posedge clk) disable iff (!rst_n) (!int_sel ##1 !int_sel) |-> ref_ready;
    endproperty
    a_nowake: assert property (p_nowake) else $error("wake delay on external");
    property p_code;
        @(posedge clk) disable iff (!rst_n)
            conv_active |=> result[arsc_pkg::RES_W-1] == ($past(raw_result[arsc_pkg::RES_W-1]) ^ $past(bipolar));
    endproperty
    a_code: assert property (p_code) else $error("result coding wrong");
    property p_auto;
        @(posedge clk) disable iff (!rst_n)
            (sel == arsc_pkg::SEL_AUTO_OFF && !conv_active && !conv_req) |=> !analog_on;
    endproperty
    a_auto: assert property (p_auto) else $error("analog not shut down");
    property p_apply;
        @(posedge clk) disable iff (!rst_n) setup_wr |=> sel == $past(setup_sel);
    endproperty
    a_apply: assert property (p_apply) else $error("select not applied");
endmodule : arsc_ctrl
`default_nettype wire

// file: verification/arsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module arsc_host (
    input wire logic clk,
    input wire logic ref_ready,
    output logic setup_wr,
    output logic [2:0] setup_sel,
    output logic setup_bipolar,
    output logic setup_diff,
    output logic conv_req
);
    initial begin
        setup_wr = 1'h0;
        setup_sel = 3'h7;
        setup_bipolar = 1'h0;
        setup_diff = 1'h0;
        conv_req = 1'h0;
    end
    // Field lines invert after the write so a stale value is never taken as fresh
    task automatic wr(input logic [2:0] s, input logic b, input logic d);
        @(negedge clk);
        setup_wr = 1'h1;
        setup_sel = s;
        setup_bipolar = b;
        setup_diff = d;
        @(negedge clk);
        setup_wr = 1'h0;
        setup_sel = ~s;
        setup_bipolar = ~b;
        setup_diff = ~d;
    endtask : wr
    // Request first: an on-demand reference wakes only on it or on conv_active, so waiting before it would hang
    task automatic start(output logic ok);
        int n;
        n = 0;
        conv_req = 1'h1;
        while (ref_ready !== 1'h1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        ok = (ref_ready === 1'h1);
    endtask : start
    task automatic stop;
        @(negedge clk);
        conv_req = 1'h0;
    endtask : stop
endmodule : arsc_host
`default_nettype wire

// file: verification/adc_reference_select_and_coding_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_reference_select_and_coding_tb;
    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    logic clk, rst_n, conv_active, diff_uses_pin, setup_wr, setup_bipolar, setup_diff, conv_req, ok;
    logic ref_internal, ref_external, ref_on, ref_ready, pin_ref_out_en, pin_ref_in, pin_force_gnd;
    logic analog_on, bipolar, diff;
    logic [2:0] setup_sel;
    logic [3:0] scan_ch, scan_limit;
    logic [9:0] raw_result, result;
    int bad_count = 0;
    int n_checks = 0;
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    arsc_ctrl #(.WAKE_CYCLES(20), .LARGE(1'b1)) arsc_ctrl_i (.clk(clk), .rst_n(rst_n), .setup_wr(setup_wr),
        .setup_sel(setup_sel), .setup_bipolar(setup_bipolar), .setup_diff(setup_diff),
        .conv_active(conv_active), .conv_req(conv_req), .scan_ch(scan_ch), .diff_uses_pin(diff_uses_pin),
        .raw_result(raw_result), .ref_internal(ref_internal), .ref_external(ref_external), .ref_on(ref_on),
        .ref_ready(ref_ready), .pin_ref_out_en(pin_ref_out_en), .pin_ref_in(pin_ref_in),
        .pin_force_gnd(pin_force_gnd), .scan_limit(scan_limit), .analog_on(analog_on), .bipolar(bipolar),
        .diff(diff), .result(result));
    arsc_host arsc_host_i (.clk(clk), .ref_ready(ref_ready), .setup_wr(setup_wr), .setup_sel(setup_sel),
        .setup_bipolar(setup_bipolar), .setup_diff(setup_diff), .conv_req(conv_req));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic end_sim;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sel;
        logic [2:0] s;
        for (int i = 0; i < 8; i++) begin
            s = i[2:0];
            arsc_host_i.wr(s, 1'h0, 1'h1);
            cyc(4);
            chk("ref_internal", ref_internal, s[2]);
            chk("ref_external", ref_external, s[2:1] == 2'h1);
            chk("pin_ref_in", pin_ref_in, s[2:1] == 2'h1);
            chk("diff", diff, 1'h1);
            chk("pin_ref_out_en", pin_ref_out_en, s[2:1] == 2'h3);
            chk("pin_force_gnd", pin_force_gnd, s[1]);
            chk("scan_limit", scan_limit, s[1] ? arsc_pkg::CH_LIMIT_LARGE : arsc_pkg::CH_LAST_LARGE);
            chk("ref_on", ref_on, s[2] & s[0]);
            chk("analog_on", analog_on, s != arsc_pkg::SEL_AUTO_OFF);
            if (!s[2]) chk("ref_ready", ref_ready, 1'h1);
        end
        scan_ch = 4'h1;
        diff_uses_pin = 1'h0;
        cyc(2);
        chk("scan_limit", scan_limit, 4'h1);
        chk("pin_force_gnd", pin_force_gnd, 1'h0);
        scan_ch = 4'hf;
        diff_uses_pin = 1'h1;
    endtask : t_sel
    task automatic t_wake;
        arsc_host_i.wr(3'h0, 1'h0, 1'h0);
        arsc_host_i.wr(3'h5, 1'h0, 1'h0);
        cyc(3);
        chk("ref_on", ref_on, 1'h1);
        chk("ref_ready", ref_ready, 1'h0);
        arsc_host_i.start(ok);
        chk("woke", ok, 1'h1);
        arsc_host_i.stop();
        arsc_host_i.wr(3'h5, 1'h0, 1'h0);
        repeat (3) begin
            cyc(1);
            chk("ref_ready", ref_ready, 1'h1);
        end
        arsc_host_i.wr(3'h4, 1'h0, 1'h0);
        cyc(4);
        chk("ref_on", ref_on, 1'h0);
        chk("analog_on", analog_on, 1'h0);
        arsc_host_i.start(ok);
        chk("woke", ok, 1'h1);
        cyc(3);
        chk("ref_on", ref_on, 1'h1);
        chk("analog_on", analog_on, 1'h1);
        arsc_host_i.stop();
    endtask : t_wake
    task automatic t_code;
        logic [9:0] v [4] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff};
        logic [9:0] e [4] = '{10'h200, 10'h1ff, 10'h000, 10'h3ff};
        for (int b = 0; b < 2; b++) begin
            arsc_host_i.wr(3'h0, b[0], 1'h0);
            conv_active = 1'h1;
            foreach (v[k]) begin
                raw_result = v[k];
                cyc(3);
                chk("result", result, b[0] ? e[k] : v[k]);
            end
            conv_active = 1'h0;
        end
        chk("bipolar", bipolar, 1'h1);
    endtask : t_code
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        rst_n = 1'h0;
        conv_active = 1'h0;
        scan_ch = 4'hf;
        diff_uses_pin = 1'h1;
        raw_result = 10'h000;
        cyc(8);
        rst_n = 1'h1;
        cyc(3);
        chk("ref_internal", ref_internal, 1'h0);
        chk("pin_ref_in", pin_ref_in | pin_ref_out_en, 1'h0);
        chk("bipolar", bipolar | diff, 1'h0);
        chk("analog_on", analog_on, 1'h1);
        t_sel();
        t_wake();
        t_code();
        end_sim();
    end
endmodule : adc_reference_select_and_coding_tb
`default_nettype wire
